// ===== include/fecs_pkg.sv
// Purpose: constants and types for the flash erase command sequencer (host side)
// Assumes: 100 MHz clock; flash bus is an 8-bit asynchronous parallel bus
// Notes: wait cycle counts below follow from CLK_MHZ, BUS_PH_CYC is fixed; no identity codes are needed
package fecs_pkg;
  localparam int ADDR_W = 18;
  localparam int CMD_AW = 11;
  localparam int CLK_MHZ = 100;
  localparam int BLK_WAIT_US = 50;
  localparam int SUSP_US = 15;
  localparam int ABORT_US = 10;
  localparam int BLK_WAIT_CYC = BLK_WAIT_US * CLK_MHZ;
  localparam int SUSP_CYC = SUSP_US * CLK_MHZ;
  localparam int ABORT_CYC = ABORT_US * CLK_MHZ;
  localparam int BUS_PH_CYC = 8;
  localparam logic [CMD_AW-1:0] ADR_UNLK1 = 11'h555;
  localparam logic [CMD_AW-1:0] ADR_UNLK2 = 11'h2aa;
  localparam logic [7:0] DAT_UNLK1 = 8'haa;
  localparam logic [7:0] DAT_UNLK2 = 8'h55;
  localparam logic [7:0] DAT_SETUP = 8'h80;
  localparam logic [7:0] DAT_CHIP = 8'h10;
  localparam logic [7:0] DAT_BLOCK = 8'h30;
  localparam logic [7:0] DAT_SUSP = 8'hb0;
  localparam logic [7:0] DAT_RESUME = 8'h30;
  localparam logic [7:0] DAT_RESET = 8'hf0;
  localparam int DQ_POLL = 7;
  localparam int DQ_TOGGLE = 6;
  localparam int DQ_ERR = 5;

  typedef enum logic [2:0] {
    FECS_OP_CHIP    = 3'b000,
    FECS_OP_BLOCK   = 3'b001,
    FECS_OP_ADD     = 3'b010,
    FECS_OP_SUSPEND = 3'b011,
    FECS_OP_RESUME  = 3'b100,
    FECS_OP_RESET   = 3'b101
  } fecs_op_t;

  typedef struct packed {
    fecs_op_t            op;
    logic [ADDR_W-1:0]   addr;
  } fecs_req_t;

  typedef struct packed {
    logic                ce_n;
    logic                oe_n;
    logic                we_n;
    logic [ADDR_W-1:0]   addr;
    logic [7:0]          dq_o;
    logic                dq_oe;
  } fecs_pins_t;
endpackage

// ===== core/fecs_bus_cycle.sv
// Purpose: one flash bus write or read cycle, phases timed by a divider enable
// Assumes: dq_i already synchronised by the caller
// Notes: strobe phases last BUS_PH_CYC clocks each
`timescale 1ns/1ns
`default_nettype none
module fecs_bus_cycle
  import fecs_pkg::*;
(
  input  wire logic              clock,
  input  wire logic              rst,
  input  wire logic              start,
  input  wire logic              is_write,
  input  wire logic [ADDR_W-1:0] addr,
  input  wire logic [7:0]        wdata,
  input  wire logic [7:0]        dq_i,
  output logic                   busy,
  output logic                   done,
  output logic [7:0]             rdata,
  output fecs_pins_t             pins
);
  logic [3:0]   div_r, div_nxt;
  logic [1:0]   ph_r, ph_nxt;
  logic         wr_r, wr_nxt;
  logic [7:0]   rd_r, rd_nxt;
  logic         dn_r, dn_nxt;
  fecs_pins_t   p_r, p_nxt;
  logic         tick;

  assign tick  = (div_r == 4'(BUS_PH_CYC - 1));
  assign busy  = (ph_r != 2'h0);
  assign done  = dn_r;
  assign rdata = rd_r;
  assign pins  = p_r;

  always_comb begin
    div_nxt = busy ? (tick ? 4'h0 : div_r + 4'h1) : 4'h0;
    ph_nxt  = ph_r;
    wr_nxt  = wr_r;
    rd_nxt  = rd_r;
    dn_nxt  = 1'b0;
    p_nxt   = p_r;
    if (!busy && start) begin
      // setup phase: address and data stable before the strobe
      ph_nxt     = 2'h1;
      wr_nxt     = is_write;
      p_nxt.addr = addr;
      p_nxt.dq_o = wdata;
      p_nxt.dq_oe = is_write;
      p_nxt.ce_n = 1'b0;
    end else if (busy && tick) begin
      unique case (ph_r)
        2'h1: begin
          ph_nxt = 2'h2;
          p_nxt.we_n = !wr_r;
          p_nxt.oe_n = wr_r;
        end
        2'h2: begin
          ph_nxt = 2'h3;
          if (!wr_r) rd_nxt = dq_i;
          p_nxt.we_n = 1'b1;
          p_nxt.oe_n = 1'b1;
        end
        2'h3: begin
          // hold phase keeps data driven past the write strobe's rising edge
          ph_nxt = 2'h0;
          dn_nxt = 1'b1;
          p_nxt.ce_n = 1'b1;
          p_nxt.dq_oe = 1'b0;
        end
        default: ph_nxt = 2'h0;
      endcase
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      div_r <= 4'h0;
      ph_r  <= 2'h0;
      wr_r  <= 1'b0;
      rd_r  <= 8'h00;
      dn_r  <= 1'b0;
      p_r   <= '{ce_n: 1'b1, oe_n: 1'b1, we_n: 1'b1, addr: '0, dq_o: 8'h00, dq_oe: 1'b0};
    end else begin
      div_r <= div_nxt;
      ph_r  <= ph_nxt;
      wr_r  <= wr_nxt;
      rd_r  <= rd_nxt;
      dn_r  <= dn_nxt;
      p_r   <= p_nxt;
    end
  end

  AST_STROBE_EXCL: assert property (@(posedge clock) disable iff (rst)
    !(p_r.we_n == 1'b0 && p_r.oe_n == 1'b0))
    else $error("write and output strobes low together");
  AST_WE_DRIVES: assert property (@(posedge clock) disable iff (rst)
    !p_r.we_n |-> p_r.dq_oe && !p_r.ce_n)
    else $error("write strobe without data driven");
endmodule
`default_nettype wire

// ===== core/fecs_host.sv
// Purpose: host controller issuing chip/block erase, suspend, resume and reset to a flash
// Assumes: one request at a time; req_ready high means a new request is taken
// Notes: after a chip erase starts or a resume, status is polled until the toggle bit stops or the DQ_ERR bit reads high twice in a row
`timescale 1ns/1ns
`default_nettype none
module fecs_host
  import fecs_pkg::*;
#(
  parameter int BLK_WAIT_CYCLES = BLK_WAIT_CYC,
  parameter int SUSP_CYCLES     = SUSP_CYC,
  parameter int ABORT_CYCLES    = ABORT_CYC
) (
  input  wire logic              clock,
  input  wire logic              rst,
  input  wire logic              req_valid,
  input  wire fecs_req_t         req,
  output logic                   req_ready,
  output logic                   done,
  output logic                   erase_err,
  output logic                   suspended,
  output logic                   flash_ce_n,
  output logic                   flash_oe_n,
  output logic                   flash_we_n,
  output logic [ADDR_W-1:0]      flash_addr,
  output logic [7:0]             flash_dq_o,
  output logic                   flash_dq_oe,
  input  wire logic [7:0]        flash_dq_i
);
  typedef enum logic [2:0] {
    ST_IDLE  = 3'b000,
    ST_SEQ   = 3'b001,
    ST_POLL  = 3'b010,
    ST_WAIT  = 3'b011,
    ST_ERR   = 3'b100
  } fecs_st_t;

  fecs_st_t            st_r, st_nxt;
  fecs_op_t            op_r, op_nxt;
  logic [ADDR_W-1:0]   ba_r, ba_nxt;
  logic [2:0]          idx_r, idx_nxt;
  logic [2:0]          last_r, last_nxt;
  logic                first_r, first_nxt;
  logic [7:0]          prev_r, prev_nxt;
  logic [31:0]         tmr_r, tmr_nxt;
  logic [31:0]         win_r, win_nxt;
  logic                rdy_r, rdy_nxt;
  logic                dn_r, dn_nxt;
  logic                err_r, err_nxt;
  logic                sus_r, sus_nxt;
  logic [7:0]          dq_s1_r, dq_s2_r;

  logic                bc_start, bc_wr, bc_busy, bc_done;
  logic [ADDR_W-1:0]   bc_addr;
  logic [7:0]          bc_wdata, bc_rdata;
  fecs_pins_t          bc_pins;

  fecs_bus_cycle u_bus (
    .clock    (clock),
    .rst      (rst),
    .start    (bc_start),
    .is_write (bc_wr),
    .addr     (bc_addr),
    .wdata    (bc_wdata),
    .dq_i     (dq_s2_r),
    .busy     (bc_busy),
    .done     (bc_done),
    .rdata    (bc_rdata),
    .pins     (bc_pins)
  );

  assign flash_ce_n  = bc_pins.ce_n;
  assign flash_oe_n  = bc_pins.oe_n;
  assign flash_we_n  = bc_pins.we_n;
  assign flash_addr  = bc_pins.addr;
  assign flash_dq_o  = bc_pins.dq_o;
  assign flash_dq_oe = bc_pins.dq_oe;
  assign req_ready   = rdy_r;
  assign done        = dn_r;
  assign erase_err   = err_r;
  assign suspended   = sus_r;

  // bypass mode is never entered, so chip and block erases always send full sequences
  // command table; upper address bits zero except block address
  always_comb begin
    bc_addr  = '0;
    bc_wdata = 8'h00;
    unique case (idx_r)
      3'h0: begin bc_addr[CMD_AW-1:0] = ADR_UNLK1; bc_wdata = DAT_UNLK1; end
      3'h1: begin bc_addr[CMD_AW-1:0] = ADR_UNLK2; bc_wdata = DAT_UNLK2; end
      3'h2: begin bc_addr[CMD_AW-1:0] = ADR_UNLK1; bc_wdata = DAT_SETUP; end
      3'h3: begin bc_addr[CMD_AW-1:0] = ADR_UNLK1; bc_wdata = DAT_UNLK1; end
      3'h4: begin bc_addr[CMD_AW-1:0] = ADR_UNLK2; bc_wdata = DAT_UNLK2; end
      default: begin
        unique case (op_r)
          FECS_OP_CHIP: begin bc_addr[CMD_AW-1:0] = ADR_UNLK1; bc_wdata = DAT_CHIP; end
          FECS_OP_SUSPEND: bc_wdata = DAT_SUSP;
          FECS_OP_RESUME:  bc_wdata = DAT_RESUME;
          FECS_OP_RESET:   bc_wdata = DAT_RESET;
          default: begin bc_addr = ba_r; bc_wdata = DAT_BLOCK; end
        endcase
      end
    endcase
  end

  always_comb begin
    st_nxt = st_r; op_nxt = op_r; ba_nxt = ba_r; idx_nxt = idx_r;
    last_nxt = last_r; first_nxt = first_r; prev_nxt = prev_r;
    tmr_nxt = (tmr_r != 0) ? tmr_r - 32'd1 : 32'd0;
    win_nxt = (win_r != 0) ? win_r - 32'd1 : 32'd0;
    rdy_nxt = 1'b0; dn_nxt = 1'b0; err_nxt = err_r; sus_nxt = sus_r;
    bc_start = 1'b0;
    bc_wr    = 1'b1;
    unique case (st_r)
      ST_IDLE: begin
        rdy_nxt = 1'b1;
        if (req_valid && rdy_r) begin
          rdy_nxt = 1'b0;
          op_nxt = req.op;
          ba_nxt = req.addr;
          st_nxt = ST_SEQ;
          idx_nxt = 3'h0;
          last_nxt = 3'h5;
          // added block only while the selection window is open
          if (req.op == FECS_OP_ADD) begin
            idx_nxt = 3'h5;
            if (win_r == 0) begin
              st_nxt = ST_IDLE;
              dn_nxt = 1'b1;
              err_nxt = 1'b1;
              rdy_nxt = 1'b1;
            end
          end else if (req.op != FECS_OP_CHIP && req.op != FECS_OP_BLOCK) begin
            idx_nxt = 3'h5;
          end
        end
      end
      ST_SEQ: begin
        bc_start = !bc_busy && !bc_done;
        if (bc_done) begin
          if (idx_r != last_r) begin
            idx_nxt = idx_r + 3'h1;
          end else begin
            first_nxt = 1'b1;
            unique case (op_r)
              // restart the selection window on each added block
              FECS_OP_BLOCK, FECS_OP_ADD: begin
                win_nxt = 32'(BLK_WAIT_CYCLES);
                st_nxt = ST_IDLE; dn_nxt = 1'b1; rdy_nxt = 1'b1;
                err_nxt = 1'b0;
              end
              // allow the engine its halt time
              FECS_OP_SUSPEND: begin
                tmr_nxt = 32'(SUSP_CYCLES); st_nxt = ST_WAIT;
                win_nxt = 32'd0; sus_nxt = 1'b1;
              end
              // abort time before any valid read
              FECS_OP_RESET: begin
                tmr_nxt = 32'(ABORT_CYCLES); st_nxt = ST_WAIT;
                err_nxt = 1'b0; sus_nxt = 1'b0; win_nxt = 32'd0;
              end
              FECS_OP_RESUME: begin sus_nxt = 1'b0; st_nxt = ST_POLL; end
              default: begin err_nxt = 1'b0; st_nxt = ST_POLL; end
            endcase
          end
        end
      end
      // poll status until the toggle bit stops or the DQ_ERR bit reads high on two reads in a row
      ST_POLL: begin
        bc_wr = 1'b0;
        bc_start = !bc_busy && !bc_done;
        if (bc_done) begin
          prev_nxt = bc_rdata;
          first_nxt = 1'b0;
          if (!first_r && (bc_rdata[DQ_TOGGLE] == prev_r[DQ_TOGGLE])) begin
            st_nxt = ST_IDLE; dn_nxt = 1'b1; rdy_nxt = 1'b1;
          end else if (!first_r && prev_r[DQ_ERR] && bc_rdata[DQ_ERR]) begin
            st_nxt = ST_ERR;
          end
        end
      end
      ST_WAIT: begin
        if (tmr_r == 0) begin
          st_nxt = ST_IDLE; dn_nxt = 1'b1; rdy_nxt = 1'b1;
        end
      end
      // failed erase: host must issue read/reset next
      ST_ERR: begin
        err_nxt = 1'b1; st_nxt = ST_IDLE; dn_nxt = 1'b1; rdy_nxt = 1'b1;
      end
      default: st_nxt = ST_IDLE;
    endcase
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      st_r <= ST_IDLE; op_r <= FECS_OP_CHIP; ba_r <= '0; idx_r <= 3'h0;
      last_r <= 3'h5; first_r <= 1'b0; prev_r <= 8'h00; tmr_r <= 32'd0;
      win_r <= 32'd0; rdy_r <= 1'b0; dn_r <= 1'b0; err_r <= 1'b0; sus_r <= 1'b0;
      dq_s1_r <= 8'h00; dq_s2_r <= 8'h00;
    end else begin
      st_r <= st_nxt; op_r <= op_nxt; ba_r <= ba_nxt; idx_r <= idx_nxt;
      last_r <= last_nxt; first_r <= first_nxt; prev_r <= prev_nxt; tmr_r <= tmr_nxt;
      win_r <= win_nxt; rdy_r <= rdy_nxt; dn_r <= dn_nxt; err_r <= err_nxt; sus_r <= sus_nxt;
      dq_s1_r <= flash_dq_i; dq_s2_r <= dq_s1_r;
    end
  end

  AST_SIXTH_WRITE: assert property (@(posedge clock) disable iff (rst)
    (st_r == ST_SEQ && bc_done && idx_r == 3'h5 && op_r == FECS_OP_CHIP) |=> st_r == ST_POLL)
    else $error("chip erase did not start polling after sixth write");
  AST_CMD_ADDR: assert property (@(posedge clock) disable iff (rst)
    (st_r == ST_SEQ && idx_r < 3'h5 && !flash_we_n) |-> flash_addr[ADDR_W-1:CMD_AW] == '0)
    else $error("upper address bits set in unlock cycle");
  AST_WINDOW: assert property (@(posedge clock) disable iff (rst)
    (st_r == ST_SEQ && bc_done && idx_r == 3'h5 && op_r == FECS_OP_BLOCK)
    |=> win_r == 32'(BLK_WAIT_CYCLES))
    else $error("selection window not restarted");
  AST_LATE_ADD: assert property (@(posedge clock) disable iff (rst)
    (st_r == ST_IDLE && rdy_r && req_valid && req.op == FECS_OP_ADD && win_r == 0)
    |=> st_r == ST_IDLE && erase_err && done)
    else $error("late block add not refused");
  AST_SUSP_WAIT: assert property (@(posedge clock) disable iff (rst)
    (st_r == ST_SEQ && bc_done && idx_r == 3'h5 && op_r == FECS_OP_SUSPEND)
    |=> st_r == ST_WAIT && tmr_r == 32'(SUSP_CYCLES) && suspended)
    else $error("suspend wait not loaded");
  AST_ABORT_WAIT: assert property (@(posedge clock) disable iff (rst)
    (st_r == ST_SEQ && bc_done && idx_r == 3'h5 && op_r == FECS_OP_RESET)
    |=> st_r == ST_WAIT && tmr_r == 32'(ABORT_CYCLES) && !erase_err)
    else $error("abort wait not loaded");
  AST_RESUME: assert property (@(posedge clock) disable iff (rst)
    (st_r == ST_SEQ && bc_done && idx_r == 3'h5 && op_r == FECS_OP_RESUME)
    |=> st_r == ST_POLL && !suspended)
    else $error("resume did not poll");
  AST_POLL_READ: assert property (@(posedge clock) disable iff (rst)
    (st_r == ST_POLL) |-> flash_we_n && !flash_dq_oe)
    else $error("write issued while polling status");
endmodule
`default_nettype wire

// ===== tb/fecs_flash_model.sv
// Purpose: behavioural flash device facing the erase host
// Assumes: host strobes move on rising clock edges; no protected blocks
// Notes: array reads return erased bytes; fail makes the next erase end in error
`timescale 1ns/1ns
`default_nettype none
module fecs_flash_model
  import fecs_pkg::*;
#(
  parameter int WAIT_CYC  = 60,
  parameter int ERASE_CYC = 300
) (
  input  wire logic              clock,
  input  wire logic              ce_n,
  input  wire logic              oe_n,
  input  wire logic              we_n,
  input  wire logic [ADDR_W-1:0] addr,
  input  wire logic [7:0]        dq_in,
  input  wire logic              dq_oe,
  input  wire logic              fail,
  output logic [7:0]             dq_out,
  output logic [7:0]             n_chip,
  output logic [7:0]             n_blk,
  output logic [7:0]             n_one,
  output logic [7:0]             n_bad,
  output logic [4:0]             last_blk
);
  logic [2:0] stage = 3'h0;
  logic chip_busy = 1'b0, blk_wait = 1'b0, blk_run = 1'b0;
  logic susp = 1'b0, err = 1'b0, tog = 1'b0, we_q = 1'b1, oe_q = 1'b1;
  logic [7:0] last_q = 8'hff;
  logic [7:0] val, d;
  logic [CMD_AW-1:0] a;
  int tmr = 0;
  logic [CMD_AW-1:0] seq_a [5] = '{ADR_UNLK1, ADR_UNLK2, ADR_UNLK1, ADR_UNLK1, ADR_UNLK2};
  logic [7:0] seq_d [5] = '{DAT_UNLK1, DAT_UNLK2, DAT_SETUP, DAT_UNLK1, DAT_UNLK2};
  wire logic busy = (chip_busy | blk_wait | blk_run | err) & ~susp;
  initial {n_chip, n_blk, n_one, n_bad, last_blk} = '0;
  // status on reads; erased array reads all ones
  always @* begin
    val = busy ? {1'b0, tog, err, 5'h00} : 8'hff;
    // released bus shows the inverse so a stale byte never passes
    dq_out = (!ce_n && !oe_n) ? val : ~last_q;
  end
  always @(posedge clock) begin
    if (!ce_n && !oe_n) last_q = val;
    if (oe_q && !oe_n && busy) tog = ~tog;
    oe_q = oe_n;
    if (blk_wait && !susp) begin
      tmr++;
      if (tmr >= WAIT_CYC) begin blk_wait = 0; blk_run = 1; tmr = 0; end
    end else if ((chip_busy || blk_run) && !susp && !err) begin
      tmr++;
      if (tmr >= ERASE_CYC) begin
        tmr = 0;
        if (fail) err = 1;
        else begin chip_busy = 0; blk_run = 0; end
      end
    end
    if (we_n && !we_q && !ce_n) begin
      a = addr[CMD_AW-1:0];
      d = dq_in;
      if (!dq_oe) n_bad++;
      if (chip_busy && !err) begin end
      else if (d == DAT_RESET) begin
        {chip_busy, blk_wait, blk_run, susp, err} = '0;
        stage = 0;
        n_one++;
      end
      else if (d == DAT_SUSP) begin n_one++; susp = blk_wait | blk_run; end
      else if (stage == 5 && a == ADR_UNLK1 && d == DAT_CHIP) begin
        chip_busy = 1; tmr = 0; stage = 0; n_chip++;
      end
      else if (stage == 5 && d == DAT_BLOCK) begin
        blk_wait = 1; tmr = 0; stage = 0; n_blk++; last_blk = addr[ADDR_W-1:13];
      end
      else if (blk_wait && !susp && d == DAT_BLOCK) begin
        tmr = 0; last_blk = addr[ADDR_W-1:13];
      end
      else if (d == DAT_RESUME) begin
        n_one++; susp = 0;
        if (blk_wait) begin blk_wait = 0; blk_run = 1; tmr = 0; end
      end
      else if (blk_wait || blk_run) begin end
      else if (stage < 5 && a == seq_a[stage] && d == seq_d[stage]) stage++;
      else begin stage = 0; n_bad++; end
    end
    we_q = we_n;
  end
endmodule
`default_nettype wire

// ===== tb/testbench.sv
// Purpose: self-checking bench for the erase host against a flash model
// Assumes: small wait parameters keep the run short
// Notes: rows hold cumulative model counters after each request
`timescale 1ns/1ns
`default_nettype none
module testbench
  import fecs_pkg::*;
;
  typedef struct packed {
    fecs_op_t          op;
    logic [ADDR_W-1:0] addr;
    logic              fail;
    logic              err;
    logic              susp;
    logic [7:0]        chip;
    logic [7:0]        blk;
    logic [7:0]        one;
    logic [4:0]        lb;
  } fecs_row_t;
  logic              clock = 1'b0;
  logic              rst = 1'b1;
  logic              req_valid = 1'b0;
  fecs_req_t         req = '0;
  logic              fail = 1'b0;
  logic              req_ready, done, erase_err, suspended;
  logic              flash_ce_n, flash_oe_n, flash_we_n, flash_dq_oe;
  logic [ADDR_W-1:0] flash_addr;
  logic [7:0]        flash_dq_o, flash_dq_i, dev_dq, n_chip, n_blk, n_one, n_bad;
  logic [4:0]        last_blk;
  int                fail_count = 0;
  int                compares = 0;
  fecs_row_t rows [10] = '{
    '{FECS_OP_CHIP, 18'h00000, 1'b0, 1'b0, 1'b0, 8'h01, 8'h00, 8'h00, 5'h00},
    '{FECS_OP_BLOCK, 18'h24000, 1'b0, 1'b0, 1'b0, 8'h01, 8'h01, 8'h00, 5'h12},
    '{FECS_OP_ADD, 18'h08000, 1'b0, 1'b0, 1'b0, 8'h01, 8'h01, 8'h00, 5'h04},
    '{FECS_OP_SUSPEND, 18'h00000, 1'b0, 1'b0, 1'b1, 8'h01, 8'h01, 8'h01, 5'h04},
    '{FECS_OP_RESUME, 18'h00000, 1'b0, 1'b0, 1'b0, 8'h01, 8'h01, 8'h02, 5'h04},
    '{FECS_OP_BLOCK, 18'h3f7ff, 1'b0, 1'b0, 1'b0, 8'h01, 8'h02, 8'h02, 5'h1f},
    '{FECS_OP_SUSPEND, 18'h00000, 1'b0, 1'b0, 1'b1, 8'h01, 8'h02, 8'h03, 5'h1f},
    '{FECS_OP_RESUME, 18'h00000, 1'b0, 1'b0, 1'b0, 8'h01, 8'h02, 8'h04, 5'h1f},
    '{FECS_OP_CHIP, 18'h00000, 1'b1, 1'b1, 1'b0, 8'h02, 8'h02, 8'h04, 5'h1f},
    '{FECS_OP_RESET, 18'h00000, 1'b0, 1'b0, 1'b0, 8'h02, 8'h02, 8'h05, 5'h1f}
  };
  // block erases are only started after the previous one was resumed and polled to its end,
  // since the device ignores new sequences while a block erase is pending
  always #5 clock = ~clock;
  // shared data pin: host while enabled, else the device
  assign flash_dq_i = flash_dq_oe ? flash_dq_o : dev_dq;
  fecs_host #(.BLK_WAIT_CYCLES(20), .SUSP_CYCLES(10), .ABORT_CYCLES(10)) dut (
    .clock, .rst, .req_valid, .req, .req_ready, .done, .erase_err, .suspended,
    .flash_ce_n, .flash_oe_n, .flash_we_n, .flash_addr, .flash_dq_o, .flash_dq_oe,
    .flash_dq_i);
  fecs_flash_model #(.WAIT_CYC(60), .ERASE_CYC(300)) flash (
    .clock, .ce_n(flash_ce_n), .oe_n(flash_oe_n), .we_n(flash_we_n), .addr(flash_addr),
    .dq_in(flash_dq_o), .dq_oe(flash_dq_oe), .fail, .dq_out(dev_dq), .n_chip, .n_blk,
    .n_one, .n_bad, .last_blk);
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      $display("ERROR %s expected %h seen %h", name, exp, seen);
      fail_count++;
    end
  endtask
  task automatic finish_test();
    if (fail_count == 0 && compares > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  task automatic run_req(input fecs_op_t op, input logic [ADDR_W-1:0] a);
    int n;
    n = 0;
    @(posedge clock);
    req_valid <= 1'b1;
    req <= '{op: op, addr: a};
    @(posedge clock);
    while (req_ready !== 1'b1 && n < 100) begin n++; @(posedge clock); end
    req_valid <= 1'b0;
    n = 0;
    do begin @(posedge clock); n++; end while (done !== 1'b1 && n < 5000);
    if (n >= 5000) fail_count++;
    #1;
  endtask
  initial begin
    fecs_row_t r;
    repeat (2) @(posedge clock);
    rst <= 1'b0;
    #1;
    check("ce_n_rst", flash_ce_n, 32'h1);
    check("ready_rst", req_ready, 32'h0);
    foreach (rows[i]) begin
      r = rows[i];
      @(posedge clock);
      fail <= r.fail;
      run_req(r.op, r.addr);
      check("erase_err", erase_err, r.err);
      check("suspended", suspended, r.susp);
      check("chip_starts", n_chip, r.chip);
      check("block_starts", n_blk, r.blk);
      check("single_cmds", n_one, r.one);
      check("block_addr", last_blk, r.lb);
    end
    // late block add: the selection window has closed, so no write may go out
    run_req(FECS_OP_BLOCK, 18'h10000);
    check("late_base_blk", n_blk, 32'h3);
    repeat (25) @(posedge clock);
    run_req(FECS_OP_ADD, 18'h20000);
    check("late_add_err", erase_err, 32'h1);
    check("late_add_blk", last_blk, 32'h08);
    check("bad_writes", n_bad, 32'h0);
    // reset in the middle of an erase sequence
    @(posedge clock);
    req_valid <= 1'b1;
    req <= '{op: FECS_OP_CHIP, addr: '0};
    repeat (60) @(posedge clock);
    rst <= 1'b1;
    req_valid <= 1'b0;
    repeat (2) @(posedge clock);
    #1;
    check("ce_n_mid", flash_ce_n, 32'h1);
    check("we_n_mid", flash_we_n, 32'h1);
    check("dq_oe_mid", flash_dq_oe, 32'h0);
    check("ready_mid", req_ready, 32'h0);
    @(posedge clock);
    rst <= 1'b0;
    repeat (3) @(posedge clock);
    #1;
    check("ready_after", req_ready, 32'h1);
    check("err_after", erase_err, 32'h0);
    check("done_after", done, 32'h0);
    finish_test();
  end
  // watchdog: the whole sequence needs well under 100 us
  initial begin
    #800000;
    fail_count++;
    finish_test();
  end
endmodule
`default_nettype wire
